/* File: flash_cmd_pkg.sv */
/*
 * constants for the host-side controller of an asynchronous dual-die flash:
 * command codes, cycle timing, operation codes of the user port.
 * assumes a 100 MHz clock; the flash has no clock of its own.
 */
// Operation
// - after 71H the next read returns global or block status chosen by address
// - after 75H the next read returns buffer data at the read address
// - after 74H the next write stores data at that cycle's buffer address
// - E0H, then low and high count, then address/data pairs from cycle four
// - host always writes 00H as high count byte
// - 0CH plus two counts; third address equals buffer source location
// - block lock is 77H then D0H at an address inside the block
// - lock bits read locked until 97H then D0H uploads them
// - after sleep F0H host also deasserts a chip enable
package flash_cmd_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;

    localparam logic [7:0] CMD_READ_EXT_STATUS = 8'h71;
    localparam logic [7:0] CMD_BUF_SWAP        = 8'h72;
    localparam logic [7:0] CMD_BUF_READ        = 8'h75;
    localparam logic [7:0] CMD_BUF_LOAD_ONE    = 8'h74;
    localparam logic [7:0] CMD_BUF_LOAD_SEQ    = 8'hE0;
    localparam logic [7:0] CMD_BUF_PROGRAM     = 8'h0C;
    localparam logic [7:0] CMD_TWO_BYTE        = 8'hFB;
    localparam logic [7:0] CMD_LOCK_BLOCK      = 8'h77;
    localparam logic [7:0] CMD_UPLOAD_STATUS   = 8'h97;
    localparam logic [7:0] CMD_READY_CONFIG    = 8'h96;
    localparam logic [7:0] CMD_SLEEP           = 8'hF0;
    localparam logic [7:0] CMD_ABORT           = 8'h80;
    localparam logic [7:0] CMD_CONFIRM         = 8'hD0;
    localparam logic [7:0] COUNT_HIGH_ZERO     = 8'h00;
    localparam logic [7:0] RB_MODE_FIRST       = 8'h01;
    localparam logic [7:0] RB_MODE_LAST        = 8'h04;

    // user-side operation codes
    localparam logic [3:0] OP_WRITE     = 4'h0; // raw single command write
    localparam logic [3:0] OP_STATUS    = 4'h1;
    localparam logic [3:0] OP_SWAP      = 4'h2;
    localparam logic [3:0] OP_BUF_READ  = 4'h3;
    localparam logic [3:0] OP_BUF_LOAD  = 4'h4;
    localparam logic [3:0] OP_SEQ_LOAD  = 4'h5;
    localparam logic [3:0] OP_BUF_PROG  = 4'h6;
    localparam logic [3:0] OP_TWO_BYTE  = 4'h7;
    localparam logic [3:0] OP_LOCK      = 4'h8;
    localparam logic [3:0] OP_UPLOAD    = 4'h9;
    localparam logic [3:0] OP_RB_CONFIG = 4'hA;
    localparam logic [3:0] OP_SLEEP     = 4'hB;
    localparam logic [3:0] OP_ABORT     = 4'hC;

    // bus cycle timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int WE_LOW_NS      = 50;
    localparam int SETUP_NS       = 20;
    localparam int READ_ACCESS_NS = 70;
    localparam int WE_LOW_CYC   = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC    = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC     = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_CNT_W    = 4;
endpackage

/* File: flash_cycle_if.sv */
/*
 * carries one flash bus cycle request from the sequencer to the pin engine.
 * assumes both ends share clk and the synchronised reset.
 */
`timescale 1ns/1ps
interface flash_cycle_if;
    logic                                valid;
    logic                                ready;
    logic                                is_read;
    logic [flash_cmd_pkg::ADDR_W-1:0]    addr;
    logic [flash_cmd_pkg::DATA_W-1:0]    wdata;
    logic                                done;
    logic [flash_cmd_pkg::DATA_W-1:0]    rdata;

    modport master (output valid, output is_read, output addr, output wdata,
                    input ready, input done, input rdata);
    modport engine (input valid, input is_read, input addr, input wdata,
                    output ready, output done, output rdata);
endinterface

/* File: flash_pin_engine.sv */
/*
 * drives one asynchronous write or read cycle on the flash pins.
 * assumes the flash latches on the rising edge of we_n, which is the
 * first control to rise here because ce_n rises one cycle later.
 */
`timescale 1ns/1ps
module flash_pin_engine (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    flash_cycle_if.engine                         cyc,
    output logic                                  ce_n,
    output logic                                  we_n,
    output logic                                  oe_n,
    output logic [flash_cmd_pkg::ADDR_W-1:0]      addr,
    output logic [flash_cmd_pkg::DATA_W-1:0]      dq_o,
    output logic                                  dq_oe,
    input  wire logic [flash_cmd_pkg::DATA_W-1:0] dq_i
);
    typedef enum logic [4:0] {
        P_IDLE  = 5'b00001,
        P_SETUP = 5'b00010,
        P_STROBE= 5'b00100,
        P_HOLD  = 5'b01000,
        P_DONE  = 5'b10000
    } pstate_t;

    typedef struct packed {
        pstate_t                          st;
        logic [flash_cmd_pkg::CYC_CNT_W-1:0] cnt;
        logic                             rd;
        logic                             ce_n;
        logic                             we_n;
        logic                             oe_n;
        logic                             dq_oe;
        logic [flash_cmd_pkg::ADDR_W-1:0] addr;
        logic [flash_cmd_pkg::DATA_W-1:0] dq;
        logic [flash_cmd_pkg::DATA_W-1:0] rdata;
    } pe_t;

    pe_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        case (s_q.st)
            P_IDLE: begin
                if (cyc.valid) begin
                    s_d.st    = P_SETUP;
                    s_d.rd    = cyc.is_read;
                    s_d.addr  = cyc.addr;
                    s_d.dq    = cyc.wdata;
                    s_d.ce_n  = 1'b0;
                    s_d.dq_oe = !cyc.is_read;
                    s_d.cnt   = flash_cmd_pkg::CYC_CNT_W'(flash_cmd_pkg::SETUP_CYC);
                end
            end
            P_SETUP: begin
                if (s_q.cnt <= 4'h1) begin
                    s_d.st   = P_STROBE;
                    s_d.we_n = s_q.rd;
                    s_d.oe_n = !s_q.rd;
                    s_d.cnt  = s_q.rd
                        ? flash_cmd_pkg::CYC_CNT_W'(flash_cmd_pkg::READ_CYC)
                        : flash_cmd_pkg::CYC_CNT_W'(flash_cmd_pkg::WE_LOW_CYC);
                end else begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end
            end
            P_STROBE: begin
                if (s_q.cnt <= 4'h1) begin
                    // we_n rises first so the latch edge is unambiguous
                    s_d.st    = P_HOLD;
                    s_d.we_n  = 1'b1;
                    s_d.oe_n  = 1'b1;
                    if (s_q.rd)
                        s_d.rdata = dq_i;
                end else begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end
            end
            P_HOLD: begin
                s_d.st    = P_DONE;
                s_d.ce_n  = 1'b1;
                s_d.dq_oe = 1'b0;
            end
            P_DONE: s_d.st = P_IDLE;
            default: s_d.st = P_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{st: P_IDLE, cnt: '0, rd: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                     oe_n: 1'b1, dq_oe: 1'b0, addr: '0, dq: '0, rdata: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign cyc.ready = (s_q.st == P_IDLE);
    assign cyc.done  = (s_q.st == P_DONE);
    assign cyc.rdata = s_q.rdata;
    assign ce_n  = s_q.ce_n;
    assign we_n  = s_q.we_n;
    assign oe_n  = s_q.oe_n;
    assign addr  = s_q.addr;
    assign dq_o  = s_q.dq;
    assign dq_oe = s_q.dq_oe;

    a_we_inside_ce: assert property (@(posedge clk) disable iff (!rst_n)
        !we_n |-> !ce_n) else $error("write strobe outside chip enable");
    a_we_rises_first: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(we_n) |-> !ce_n) else $error("chip enable rose before write strobe");
endmodule // flash_pin_engine

/* File: flash_cmd_host.sv */
/*
 * host controller issuing the extended command set to the flash.
 * one user operation expands into its documented sequence of bus cycles.
 * assumes op fields are valid in the cycle op_valid is high with op_ready high; they are registered then.
 */
`timescale 1ns/1ps
module flash_cmd_host (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire logic                             op_valid,
    output logic                                  op_ready,
    input  wire logic [3:0]                       op_code,
    input  wire logic [flash_cmd_pkg::ADDR_W-1:0] op_addr,
    input  wire logic [flash_cmd_pkg::DATA_W-1:0] op_data,
    input  wire logic [7:0]                       op_arg,
    input  wire logic                             byte_mode,
    output logic                                  data_req,
    input  wire logic [flash_cmd_pkg::ADDR_W-1:0] data_addr,
    input  wire logic [flash_cmd_pkg::DATA_W-1:0] data_word,
    output logic                                  rd_valid,
    output logic [flash_cmd_pkg::DATA_W-1:0]      rd_data,
    output logic                                  op_done,
    input  wire logic                             ready_busy_out,
    output logic                                  engine_busy,
    output logic                                  chip_enable_primary_n,
    output logic                                  we_n,
    output logic                                  oe_n,
    output logic [flash_cmd_pkg::ADDR_W-1:0]      addr,
    output logic [flash_cmd_pkg::DATA_W-1:0]      dq_o,
    output logic                                  dq_oe,
    input  wire logic [flash_cmd_pkg::DATA_W-1:0] dq_i
);
    logic [1:0] rst_sync;
    logic       rst_n_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n_s = rst_sync[1];

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_ISSUE= 5'b00010,
        S_WAIT = 5'b00100,
        S_NEXT = 5'b01000,
        S_END  = 5'b10000
    } state_t;

    typedef struct packed {
        state_t                           st;
        logic [3:0]                       op;
        logic [2:0]                       idx;
        logic [8:0]                       left;
        logic [flash_cmd_pkg::ADDR_W-1:0] a;
        logic [flash_cmd_pkg::DATA_W-1:0] d;
        logic [7:0]                       arg;
        logic                             bm;
        logic                             rv;
        logic [flash_cmd_pkg::DATA_W-1:0] rdat;
        logic                             done;
        logic                             rb;
    } host_t;

    host_t s_q, s_d;

    flash_cycle_if cyc ();

    flash_pin_engine u_pins (
        .clk   (clk),
        .rst_n (rst_n_s),
        .cyc   (cyc),
        .ce_n  (chip_enable_primary_n),
        .we_n  (we_n),
        .oe_n  (oe_n),
        .addr  (addr),
        .dq_o  (dq_o),
        .dq_oe (dq_oe),
        .dq_i  (dq_i)
    );

    // bus cycle for the current step, from op and index
    logic                              c_rd;
    logic                              c_last;
    logic [flash_cmd_pkg::ADDR_W-1:0]  c_addr;
    logic [7:0]                        c_lo;
    logic [flash_cmd_pkg::DATA_W-1:0]  c_data;
    logic                              c_pay;

    always_comb begin
        c_rd   = 1'b0;
        c_last = 1'b0;
        c_addr = '0;
        c_lo   = 8'h00;
        c_data = '0;
        c_pay  = 1'b0;
        case (s_q.op)
            flash_cmd_pkg::OP_STATUS: begin
                c_lo = flash_cmd_pkg::CMD_READ_EXT_STATUS;
                c_rd = (s_q.idx == 3'd1);
                c_addr = s_q.a;
                c_last = c_rd;
            end
            flash_cmd_pkg::OP_SWAP: begin
                c_lo = flash_cmd_pkg::CMD_BUF_SWAP;
                c_last = 1'b1;
            end
            flash_cmd_pkg::OP_BUF_READ: begin
                c_lo = flash_cmd_pkg::CMD_BUF_READ;
                c_rd = (s_q.idx == 3'd1);
                c_addr = s_q.a;
                c_last = c_rd;
            end
            flash_cmd_pkg::OP_BUF_LOAD: begin
                c_lo = flash_cmd_pkg::CMD_BUF_LOAD_ONE;
                if (s_q.idx == 3'd1) begin
                    c_addr = s_q.a;
                    c_data = s_q.d;
                    c_pay  = 1'b1;
                    c_last = 1'b1;
                end
            end
            flash_cmd_pkg::OP_SEQ_LOAD: begin
                case (s_q.idx)
                    3'd0: c_lo = flash_cmd_pkg::CMD_BUF_LOAD_SEQ;
                    3'd1: c_lo = s_q.arg; // user passes count minus one
                    3'd2: c_lo = flash_cmd_pkg::COUNT_HIGH_ZERO;
                    default: begin
                        c_addr = data_addr; // pairs from cycle four
                        c_data = data_word;
                        c_pay  = 1'b1;
                        c_last = (s_q.left == 9'd1);
                    end
                endcase
            end
            flash_cmd_pkg::OP_BUF_PROG, flash_cmd_pkg::OP_TWO_BYTE: begin
                // byte mode: second cycle A0 picks order, third at the destination address
                case (s_q.idx)
                    3'd0: c_lo = (s_q.op == flash_cmd_pkg::OP_TWO_BYTE)
                                 ? flash_cmd_pkg::CMD_TWO_BYTE
                                 : flash_cmd_pkg::CMD_BUF_PROGRAM;
                    3'd1: begin
                        c_addr = {{(flash_cmd_pkg::ADDR_W-1){1'b0}}, s_q.a[0]};
                        c_lo = (s_q.op == flash_cmd_pkg::OP_TWO_BYTE)
                               ? (s_q.a[0] ? s_q.d[15:8] : s_q.d[7:0])
                               : (s_q.a[0] && s_q.bm ? flash_cmd_pkg::COUNT_HIGH_ZERO
                                                     : s_q.arg);
                    end
                    default: begin
                        c_addr = s_q.a; // destination equals buffer source
                        c_lo = (s_q.op == flash_cmd_pkg::OP_TWO_BYTE)
                               ? (s_q.a[0] ? s_q.d[7:0] : s_q.d[15:8])
                               : (s_q.a[0] && s_q.bm ? s_q.arg
                                                     : flash_cmd_pkg::COUNT_HIGH_ZERO);
                        c_last = 1'b1;
                    end
                endcase
            end
            flash_cmd_pkg::OP_LOCK: begin
                c_lo = (s_q.idx == 3'd0) ? flash_cmd_pkg::CMD_LOCK_BLOCK
                                         : flash_cmd_pkg::CMD_CONFIRM;
                c_addr = s_q.a;
                c_last = (s_q.idx == 3'd1);
            end
            flash_cmd_pkg::OP_UPLOAD: begin
                c_lo = (s_q.idx == 3'd0) ? flash_cmd_pkg::CMD_UPLOAD_STATUS
                                         : flash_cmd_pkg::CMD_CONFIRM;
                c_last = (s_q.idx == 3'd1);
            end
            flash_cmd_pkg::OP_RB_CONFIG: begin
                c_lo = (s_q.idx == 3'd0) ? flash_cmd_pkg::CMD_READY_CONFIG
                                         : s_q.arg;
                c_last = (s_q.idx == 3'd1);
            end
            flash_cmd_pkg::OP_SLEEP: begin
                c_lo = flash_cmd_pkg::CMD_SLEEP; // enable rises after each cycle
                c_last = 1'b1;
            end
            flash_cmd_pkg::OP_ABORT: begin
                c_lo = flash_cmd_pkg::CMD_ABORT;
                c_last = 1'b1;
            end
            default: begin
                c_lo = s_q.d[7:0];
                c_addr = s_q.a;
                c_last = 1'b1;
            end
        endcase
        // upper byte zero on command cycles, which the device ignores
        // payload flag, not a zero test: a zero data word must stay zero
        if (!c_pay)
            c_data = {8'h00, c_lo};
    end

    assign cyc.valid   = (s_q.st == S_ISSUE);
    assign cyc.is_read = c_rd;
    assign cyc.addr    = c_addr;
    assign cyc.wdata   = c_data;

    always_comb begin
        s_d = s_q;
        s_d.rv = 1'b0;
        s_d.done = 1'b0;
        s_d.rb = ready_busy_out;
        case (s_q.st)
            S_IDLE: begin
                if (op_valid) begin
                    s_d.st   = S_ISSUE;
                    s_d.op   = op_code;
                    s_d.idx  = 3'd0;
                    s_d.a    = op_addr;
                    s_d.d    = op_data;
                    s_d.arg  = op_arg;
                    s_d.bm   = byte_mode;
                    s_d.left = {1'b0, op_arg} + 9'd1;
                    if (op_code == flash_cmd_pkg::OP_RB_CONFIG &&
                        (op_arg < flash_cmd_pkg::RB_MODE_FIRST ||
                         op_arg > flash_cmd_pkg::RB_MODE_LAST))
                        s_d.st = S_END; // refuse undefined mode codes
                end
            end
            S_ISSUE: if (cyc.ready) s_d.st = S_WAIT;
            S_WAIT: begin
                if (cyc.done) begin
                    if (c_rd) begin
                        s_d.rv = 1'b1;
                        s_d.rdat = cyc.rdata;
                    end
                    if (s_q.op == flash_cmd_pkg::OP_SEQ_LOAD && s_q.idx == 3'd3)
                        s_d.left = s_q.left - 9'd1;
                    s_d.st = c_last ? S_END : S_NEXT;
                end
            end
            S_NEXT: begin
                s_d.st = S_ISSUE;
                if (s_q.idx != 3'd3)
                    s_d.idx = s_q.idx + 3'd1;
            end
            S_END: begin
                s_d.done = 1'b1;
                s_d.st = S_IDLE;
            end
            default: s_d.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s)
            s_q <= '{st: S_IDLE, op: '0, idx: '0, left: '0, a: '0, d: '0, arg: '0,
                     bm: 1'b0, rv: 1'b0, rdat: '0, done: 1'b0, rb: 1'b1};
        else
            s_q <= s_d;
    end

    assign op_ready    = (s_q.st == S_IDLE);
    // one clock per pair; user presents the pair while data_req is high
    assign data_req    = (s_q.st == S_ISSUE) && cyc.ready &&
                         s_q.op == flash_cmd_pkg::OP_SEQ_LOAD && s_q.idx == 3'd3;
    assign rd_valid    = s_q.rv;
    assign rd_data     = s_q.rdat;
    assign op_done     = s_q.done;
    // level mode: low means engine busy
    assign engine_busy = !s_q.rb;

    a_cmd_upper_zero: assert property (@(posedge clk) disable iff (!rst_n_s)
        cyc.valid && s_q.idx == 3'd0 |-> cyc.wdata[15:8] == 8'h00)
        else $error("command cycle upper byte not zero");
    a_seq_high_zero: assert property (@(posedge clk) disable iff (!rst_n_s)
        cyc.valid && s_q.op == flash_cmd_pkg::OP_SEQ_LOAD && s_q.idx == 3'd2
        |-> cyc.wdata == 16'h0000) else $error("high count not zero");
    a_lock_confirm: assert property (@(posedge clk) disable iff (!rst_n_s)
        cyc.valid && s_q.op == flash_cmd_pkg::OP_LOCK && s_q.idx == 3'd1
        |-> cyc.wdata[7:0] == 8'hD0 && cyc.addr == s_q.a)
        else $error("lock confirm wrong");
    a_status_read: assert property (@(posedge clk) disable iff (!rst_n_s)
        cyc.valid && s_q.op == flash_cmd_pkg::OP_STATUS |-> c_rd == (s_q.idx == 3'd1))
        else $error("status read cycle misplaced");
    a_two_byte_comp: assert property (@(posedge clk) disable iff (!rst_n_s)
        cyc.valid && s_q.op == flash_cmd_pkg::OP_TWO_BYTE && s_q.idx == 3'd1
        |-> cyc.wdata[7:0] == (s_q.a[0] ? s_q.d[15:8] : s_q.d[7:0]))
        else $error("two byte order wrong");
    a_swap_single: assert property (@(posedge clk) disable iff (!rst_n_s)
        cyc.valid && s_q.op == flash_cmd_pkg::OP_SWAP |-> c_last)
        else $error("swap not single cycle");
    a_done_pulse: assert property (@(posedge clk) disable iff (!rst_n_s)
        op_done |-> op_ready ##1 !op_done) else $error("done not a pulse");
    a_busy_level: assert property (@(posedge clk) disable iff (!rst_n_s)
        !$past(ready_busy_out) |-> engine_busy) else $error("busy not followed");

    c_seq_load: cover property (@(posedge clk) disable iff (!rst_n_s)
        data_req ##[1:200] op_done);
    c_status_rd: cover property (@(posedge clk) disable iff (!rst_n_s)
        rd_valid && s_q.op == flash_cmd_pkg::OP_STATUS);
    c_lock: cover property (@(posedge clk) disable iff (!rst_n_s)
        op_done && s_q.op == flash_cmd_pkg::OP_LOCK);
endmodule // flash_cmd_host

/* File: flash_dev_model.sv */
/* device stand-in: logs write cycles, answers reads.
   assumes active-low strobes from the host. */
`timescale 1ns/1ps
module flash_dev_model (
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [20:0] addr,
    input  wire logic [15:0] dq_o,
    output logic      [15:0] dq_i,
    input  wire logic        busy,
    output logic             ready_busy_out
);
    logic [20:0] wa [256];
    logic [7:0]  wd [256];
    int          n_wr = 0;
    logic [7:0]  cmd_q = 8'hFF;
    logic [15:0] last_q = 16'h0000;
    // whichever strobe rises first closes the cycle
    always @(posedge we_n or posedge ce_n) begin
        if (ce_n ^ we_n) begin
            wa[n_wr] = addr;
            wd[n_wr] = dq_o[7:0];
            cmd_q = dq_o[7:0];
            n_wr = n_wr + 1;
        end
    end
    // released bus shows inverse of last value, never a stale match
    always @* begin
        if (!oe_n && !ce_n) begin
            dq_i = (cmd_q == 8'h71) ? {8'h00, addr[7:0] ^ 8'hA5} : {addr[7:0], ~addr[7:0]};
            last_q = dq_i;
        end else dq_i = ~last_q;
    end
    assign ready_busy_out = ~busy;
endmodule // flash_dev_model

/* File: test_flash_enhanced_command_decoder.sv */
/* fixed operation sequence with random addresses and data against the device model; write cycles and reads checked.
   assumes a 100 MHz clock. */
`timescale 1ns/1ps
module test_flash_enhanced_command_decoder;
    logic        clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, byte_mode = 1'b0, busy = 1'b0;
    logic [3:0]  op_code = 4'h0;
    logic [20:0] op_addr = 21'h0, a, addr;
    logic [15:0] op_data = 16'h0, d, rd_data, dq_o, dq_i;
    logic [7:0]  op_arg = 8'h00, g, pi = 8'h00;
    logic [15:0] pw [256];
    logic        op_ready, data_req, op_done, rbo, engine_busy, ce_n, we_n, oe_n, rd_valid, dq_oe;
    logic [21:0] ea [$];
    logic [7:0]  ed [$];
    int          err_total = 0, checks_done = 0, base = 0, seed = 32'h687b;
    always #5 clk = ~clk;
    always @(posedge clk) if (data_req === 1'b1) pi <= pi + 8'h01;
    flash_cmd_host dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready),
        .op_code(op_code), .op_addr(op_addr), .op_data(op_data), .op_arg(op_arg),
        .byte_mode(byte_mode), .data_req(data_req), .data_addr({13'h0000, pi}),
        .data_word(pw[pi]), .rd_valid(rd_valid), .rd_data(rd_data), .op_done(op_done),
        .ready_busy_out(rbo), .engine_busy(engine_busy), .chip_enable_primary_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
    flash_dev_model m (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o),
        .dq_i(dq_i), .busy(busy), .ready_busy_out(rbo));
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_d(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask
    // care bit in 21 masks don't-care addresses
    task automatic exp_w(input logic c, input logic [20:0] ad, input logic [7:0] dt);
        ea.push_back({c, ad});
        ed.push_back(dt);
    endtask
    task automatic run_op(input logic [3:0] c, input logic [7:0] ag);
        int t;
        int nrv;
        op_code = c;
        op_addr = a;
        op_data = d;
        op_arg = ag;
        pi = 8'h00;
        op_valid = 1'b1;
        @(posedge clk);
        #1;
        op_valid = 1'b0;
        t = 0;
        nrv = 0;
        while (op_done !== 1'b1 && t < 3000) begin
            @(posedge clk);
            #1;
            t++;
            if (rd_valid === 1'b1) nrv++;
        end
        chk_d(16'(nrv), 16'(c == flash_cmd_pkg::OP_STATUS ||
                            c == flash_cmd_pkg::OP_BUF_READ));
        chk_d(16'(m.n_wr - base), 16'(ea.size()));
        if (t == 3000) chk_d(16'h0001, 16'h0000);
        foreach (ea[i]) begin
            chk_d({8'h00, m.wd[base+i]}, {8'h00, ed[i]});
            if (ea[i][21]) chk_d(m.wa[base+i][15:0], ea[i][15:0]);
        end
        base = m.n_wr;
        ea.delete();
        ed.delete();
    endtask
    initial begin
        for (int i = 0; i < 256; i++) pw[i] = 16'($random(seed));
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        // both bus widths, both first-byte orders; count zero first
        for (int i = 0; i < 4; i++) begin
            byte_mode = i[0];
            a = {20'($random(seed)), i[1]};
            d = 16'($random(seed));
            g = (i == 0) ? 8'h00 : 8'($random(seed) & 7);
            exp_w(1'b1, a, d[7:0]);
            run_op(flash_cmd_pkg::OP_WRITE, g);
            exp_w(1'b0, a, 8'h71);
            run_op(flash_cmd_pkg::OP_STATUS, g);
            chk_d(rd_data, {8'h00, a[7:0] ^ 8'hA5});
            exp_w(1'b0, a, 8'h72);
            run_op(flash_cmd_pkg::OP_SWAP, g);
            exp_w(1'b0, a, 8'h75);
            run_op(flash_cmd_pkg::OP_BUF_READ, g);
            chk_d(rd_data, {a[7:0], ~a[7:0]});
            exp_w(1'b0, a, 8'h74);
            exp_w(1'b1, a, d[7:0]);
            run_op(flash_cmd_pkg::OP_BUF_LOAD, g);
            exp_w(1'b0, a, 8'hE0);
            exp_w(1'b0, a, g);
            exp_w(1'b0, a, 8'h00);
            for (int k = 0; k <= g; k++) exp_w(1'b1, 21'(k), pw[k][7:0]);
            run_op(flash_cmd_pkg::OP_SEQ_LOAD, g);
            exp_w(1'b0, a, 8'h0C);
            exp_w(byte_mode, {20'h0, a[0]}, (byte_mode && a[0]) ? 8'h00 : g);
            exp_w(1'b1, a, (byte_mode && a[0]) ? g : 8'h00);
            run_op(flash_cmd_pkg::OP_BUF_PROG, g);
            if (byte_mode) begin
                exp_w(1'b0, a, 8'hFB);
                exp_w(1'b1, {20'h0, a[0]}, a[0] ? d[15:8] : d[7:0]);
                exp_w(1'b1, a, a[0] ? d[7:0] : d[15:8]);
                run_op(flash_cmd_pkg::OP_TWO_BYTE, g);
            end
            exp_w(1'b0, a, 8'h77);
            exp_w(1'b1, a, 8'hD0);
            run_op(flash_cmd_pkg::OP_LOCK, g);
            exp_w(1'b0, a, 8'h97);
            exp_w(1'b0, a, 8'hD0);
            run_op(flash_cmd_pkg::OP_UPLOAD, g);
            // 0 and 5 must be refused with no bus cycle
            for (int k = 0; k < 6; k++) begin
                if (k > 0 && k < 5) exp_w(1'b0, a, 8'h96);
                if (k > 0 && k < 5) exp_w(1'b0, a, 8'(k));
                run_op(flash_cmd_pkg::OP_RB_CONFIG, 8'(k));
            end
            exp_w(1'b0, a, 8'hF0);
            run_op(flash_cmd_pkg::OP_SLEEP, g);
            chk_d({13'h0000, op_ready, dq_oe, ce_n}, 16'h0005);
            exp_w(1'b0, a, 8'h80);
            run_op(flash_cmd_pkg::OP_ABORT, g);
        end
        busy = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk_d({15'h0000, engine_busy}, 16'h0001);
        busy = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_d({15'h0000, engine_busy}, 16'h0000);
        complete_run();
    end
    initial begin
        // roughly twenty times the expected length of the run
        #300000;
        err_total++;
        complete_run();
    end
endmodule // test_flash_enhanced_command_decoder
